// file: pkg/board_timestamp_clock_defs.vh
// constants for the board time-of-day counter
// Functional notes
// - time word is 64 bits; upper 32 hold low 32 bits of epoch seconds
// - lower 32 bits are a binary fraction of one second
// - only top twenty fraction bits count; low twelve read zero
// - adjustment counter overflow adds or holds one fraction step
// - fraction step may repeat or jump by two; accuracy one lsb
// - time-code mode runs rate adjustment automatically without software
// - software may load full seconds and fraction in one write
// - counting starts right after configuration, no enable needed
// - one counter shared by every channel
// - full 64-bit read with seconds and fraction from one instant
`ifndef BOARD_TIMESTAMP_CLOCK_DEFS_VH
`define BOARD_TIMESTAMP_CLOCK_DEFS_VH
`define FRAC_BITS        20
`define FRAC_PAD_BITS    12
`define SEC_RESET        32'h0000_0000
`define FRAC_RESET       20'h0_0000
`define TICK_FREQ_HZ     1048576
`define CLK_FREQ_HZ      250000000
// clocks per fraction step, 250e6 / 2^20 truncated
`define TICK_DIV_CYCLES  16'h00ee
`define ADJ_PERIOD_RESET 32'h0000_0000
`endif

// file: rtl/board_timestamp_clock.v
// board time-of-day counter with rate trim
`timescale 1ns/1ns
`include "board_timestamp_clock_defs.vh"
module board_timestamp_clock (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // time load
  input  wire        load,
  input  wire [63:0] load_time,
  // rate trim from software
  input  wire [31:0] adj_period,
  input  wire        adj_add,
  input  wire        adj_enable,
  // hardware time code trim
  input  wire        timecode_mode,
  input  wire        timecode_fast,
  input  wire        timecode_slow,
  // read side
  input  wire        read_req,
  output reg         read_valid,
  output reg  [63:0] read_time,
  output wire [63:0] time_now
);

  ////////////////////////////////////////////////////////////////////
  localparam [15:0] TICK_DIV = `TICK_DIV_CYCLES;

  reg [15:0] div_r;
  reg [31:0] sec_r;
  reg [19:0] frac_r;
  reg [31:0] adj_cnt_r;
  reg        adj_pend_r;
  reg        adj_dir_r;
  reg [19:0] frac_nxt;
  reg [31:0] sec_nxt;
  reg [1:0]  step;
  wire       tick;
  wire       sw_adj;
  wire       adj_wrap;
  wire       hw_adj;

  assign tick     = (div_r == TICK_DIV - 16'h0001);
  assign sw_adj   = adj_enable && !timecode_mode && (adj_period != 32'h0000_0000);
  assign adj_wrap = sw_adj && (adj_cnt_r >= adj_period - 32'h0000_0001);
  assign hw_adj   = timecode_mode && (timecode_fast || timecode_slow);

  // time word, fraction low bits zero; single shared counter
  assign time_now = {sec_r, frac_r, {`FRAC_PAD_BITS{1'b0}}};

  ////////////////////////////////////////////////////////////////////
  // fraction step: 0 hold, 1 normal, 2 jump
  always @* begin
    step = 2'd1;
    // add or hold on pending adjustment
    if (adj_pend_r) begin
      if (adj_dir_r) begin
        step = 2'd2;
      end else begin
        step = 2'd0;
      end
    end
    {sec_nxt, frac_nxt} = {sec_r, frac_r} + {50'd0, step};
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (srst) begin
      // counts from reset release without enable
      div_r      <= 16'h0000;
      sec_r      <= `SEC_RESET;
      frac_r     <= `FRAC_RESET;
      adj_cnt_r  <= `ADJ_PERIOD_RESET;
      adj_pend_r <= 1'b0;
      adj_dir_r  <= 1'b0;
      read_valid <= 1'b0;
      read_time  <= 64'h0000_0000_0000_0000;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
      if (!sw_adj) begin
        adj_cnt_r <= 32'h0000_0000;
      end else if (adj_wrap) begin
        adj_cnt_r <= 32'h0000_0000;
      end else begin
        adj_cnt_r <= adj_cnt_r + 32'h0000_0001;
      end
      if (hw_adj) begin
        adj_pend_r <= 1'b1;
        adj_dir_r  <= timecode_slow;
      end else if (adj_wrap) begin
        adj_pend_r <= 1'b1;
        adj_dir_r  <= adj_add;
      end else if (tick && !load) begin
        adj_pend_r <= 1'b0;
      end
      if (load) begin
        sec_r      <= load_time[63:32];
        frac_r     <= load_time[31:12];
        adj_pend_r <= 1'b0;
      end else if (tick) begin
        sec_r  <= sec_nxt;
        frac_r <= frac_nxt;
      end
      read_valid <= read_req;
      if (read_req) begin
        read_time <= time_now;
      end
    end
  end

endmodule // board_timestamp_clock

// file: testbench/board_timestamp_clock_sva.sv
// assertions for the time counter
`timescale 1ns/1ns
module board_timestamp_clock_sva (
  input wire        clk, srst, load, read_req, read_valid, timecode_mode,
  input wire        adj_enable, adj_add, timecode_fast, timecode_slow,
  input wire [31:0] adj_period,
  input wire [63:0] load_time, read_time, time_now
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // any trim setting that may hold the fraction
  wire       hold_req = (adj_enable && !timecode_mode && !adj_add && adj_period != 0) ||
                        (timecode_mode && timecode_fast && !timecode_slow);
  logic [9:0] still_cnt;
  always @(posedge clk) begin
    if (srst || hold_req || load || $changed(time_now)) still_cnt <= 10'h000;
    else if (still_cnt != 10'h3ff) still_cnt <= still_cnt + 10'h001;
  end
  a_pad_zero: assert property (time_now[11:0] == 0) else $error("pad");
  a_load_take: assert property (load |=> time_now == ($past(load_time) & ~64'hfff))
    else $error("load");
  a_read_ans: assert property (read_req |=> read_valid) else $error("valid");
  a_valid_why: assert property (read_valid |-> $past(read_req)) else $error("spur");
  a_snap_same: assert property (read_req |=> read_time == $past(time_now))
    else $error("snap");
  a_snap_hold: assert property (!read_req |=> $stable(read_time)) else $error("hold");
  a_step_max: assert property (!load |=> time_now - $past(time_now) <= 64'h2000)
    else $error("step");
  a_runs_free: assert property (still_cnt < 10'd480) else $error("run");
  c_load: cover property (load);
  c_read: cover property (read_valid);
  c_tc: cover property (timecode_mode && read_valid);
endmodule // board_timestamp_clock_sva
bind board_timestamp_clock board_timestamp_clock_sva i_board_timestamp_clock_sva (.clk, .srst,
  .load, .read_req, .read_valid, .timecode_mode, .adj_enable, .adj_add, .timecode_fast,
  .timecode_slow, .adj_period, .load_time, .read_time, .time_now);

// file: testbench/tb_board_timestamp_clock.sv
// bench for the time counter
`timescale 1ns/1ns
module tb_board_timestamp_clock;
  logic        clk = 0, srst = 1, load = 0, adj_add = 0, adj_enable = 0, read_valid;
  logic        timecode_mode = 0, timecode_fast = 0, timecode_slow = 0, read_req = 0;
  logic [63:0] load_time = 0, read_time, time_now, l;
  logic [31:0] adj_period = 0;
  int          miscompares = 0, n_tests = 0, cyc = 0, d;
  always #2 clk = ~clk;
  board_timestamp_clock i_board_timestamp_clock (.clk, .srst, .load, .load_time, .adj_period,
    .adj_add, .adj_enable, .timecode_mode, .timecode_fast, .timecode_slow, .read_req,
    .read_valid, .read_time, .time_now);
  task automatic check(logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // steps within one lsb per tick of the nominal count
  function automatic logic near(int s, int k);
    near = s >= 3 * k && s <= 5 * k;
  endfunction
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 20000) begin
    miscompares++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h2fbd_fe1b));
    repeat (6) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    #1 check(read_time, 64'h0);
    repeat (480) @(posedge clk);
    #1 check(time_now != 0, 64'h1);
    // nominal, sw add, sw hold, code slow, code fast
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      l = {$urandom, $urandom} & ~64'hfff;
      load <= 1;
      load_time <= l | $urandom_range(4095);
      // corrections only by trim, one lsb per step
      adj_period <= 1;
      adj_enable <= i == 1 || i == 2;
      adj_add <= i == 1;
      timecode_mode <= i > 2;
      timecode_slow <= i == 3;
      timecode_fast <= i == 4;
      @(posedge clk);
      load <= 0;
      #1 check(time_now, l);
      repeat (951) @(posedge clk);
      read_req <= 1;
      @(posedge clk);
      read_req <= 0;
      #1 check(read_valid, 64'h1);
      d = (read_time - l) >> 12;
      check(near(d, i == 0 ? 1 : i % 2 ? 2 : 0), 64'h1);
    end
    tally_and_finish;
  end
endmodule // tb_board_timestamp_clock
